// [core/io_expander_host.sv]
// Purpose: Bus master that writes and reads a remote 8-bit I/O expander.
// Assumes: Single clock; the master makes the serial clock by division.
// Notes:   Open-drain pins come out as value/enable pairs; no stretching.
`timescale 1ns/1ps
module io_expander_host #(
   parameter logic [3:0] ADDR_HI = 4'h4    // Fixed upper address bits
) (
   // Clock and reset
   input  wire logic                         ref_clk_in,
   input  wire logic                         srst_in,
   // User command port
   input  wire logic                         cmd_valid_in,
   input  wire io_expander_host_pkg::cmd_type cmd_in,
   output logic                              cmd_ready_out,
   // Read data and completion
   output logic                              rsp_valid_out,
   output io_expander_host_pkg::rsp_type     rsp_out,
   output logic                              done_out,
   output logic                              nack_out,
   output logic                              alert_out,
   // Serial clock pin, open drain
   input  wire logic                         scl_in,
   output logic                              scl_out,
   output logic                              scl_oe_out,
   // Serial data pin, open drain
   input  wire logic                         sda_in,
   output logic                              sda_out,
   output logic                              sda_oe_out,
   // Alert line from the expander, active low
   input  wire logic                         alert_n_in
);

   // Synchronised pin levels
   logic                               scl_s;
   logic                               sda_s;
   logic                               alert_n_s;

   // Bus machine state
   io_expander_host_pkg::state_type    st_q, st_d;
   logic [1:0]                         phase_q, phase_d;   // Quarter of bit
   logic [io_expander_host_pkg::QCNT_W-1:0] qcnt_q, qcnt_d;
   logic [io_expander_host_pkg::FREE_W-1:0] free_q, free_d;
   logic [3:0]                         bit_q, bit_d;       // 0..7 data, 8 ack
   logic [7:0]                         shreg_q, shreg_d;   // Shift register
   logic                               rx_q, rx_d;         // Byte comes from slave
   logic                               addr_q, addr_d;     // Address byte pending
   logic                               ack_q, ack_d;       // Sampled ack level
   io_expander_host_pkg::cmd_type      cmd_q, cmd_d;       // Held command
   logic [7:0]                         left_q, left_d;     // Read bytes left
   logic                               scl_oe_q, scl_oe_d;
   logic                               sda_oe_q, sda_oe_d;
   // Registered answers
   logic                               rsp_valid_q, rsp_valid_d;
   io_expander_host_pkg::rsp_type      rsp_q, rsp_d;
   logic                               done_q, done_d;
   logic                               nack_q, nack_d;
   // Derived
   logic                               tick;               // End of a quarter
   logic                               bus_free;           // Idle long enough
   logic                               in_idle, in_bit, in_ack; // State decodes
   default clocking cb_ref @(posedge ref_clk_in); endclocking  // Checks sample here
   default disable iff (srst_in);                               // Checks rest in reset

   // Pins cross into the clock domain before any use
   pin_sync #(
      .WIDTH   (3),
      .RST_VAL (32'h00000007)
   ) u_sync (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .pin_in     ({scl_in, sda_in, alert_n_in}),
      .sync_out   ({scl_s, sda_s, alert_n_s})
   );
   assign in_idle  = (st_q == io_expander_host_pkg::S_IDLE);
   assign in_bit   = (st_q == io_expander_host_pkg::S_BIT);
   assign in_ack   = in_bit && (bit_q == io_expander_host_pkg::ACK_BIT);

   assign tick     = (qcnt_q == io_expander_host_pkg::QCNT_W'(
                      io_expander_host_pkg::QUARTER_CYC - 1));
   assign bus_free = (free_q == io_expander_host_pkg::FREE_W'(
                      io_expander_host_pkg::FREE_CYC));

   // Next-state logic for the whole bus sequence
   always_comb begin
      st_d        = st_q;
      phase_d     = phase_q;
      free_d      = free_q;
      bit_d       = bit_q;
      shreg_d     = shreg_q;
      rx_d        = rx_q;
      addr_d      = addr_q;
      ack_d       = ack_q;
      cmd_d       = cmd_q;
      left_d      = left_q;
      scl_oe_d    = scl_oe_q;
      sda_oe_d    = sda_oe_q;
      rsp_valid_d = 1'b0;
      rsp_d       = rsp_q;
      done_d      = 1'b0;
      nack_d      = nack_q;

      // Quarter timer runs only during a transaction
      qcnt_d = (in_idle || tick) ? '0 : qcnt_q + io_expander_host_pkg::QCNT_W'(1);
      if (!in_idle && tick) begin
         phase_d = phase_q + 2'h1;
      end

      // Bus counts as free only after both lines sit high long enough
      if (!(in_idle && scl_s && sda_s)) begin
         free_d = '0;
      end else if (!bus_free) begin
         free_d = free_q + io_expander_host_pkg::FREE_W'(1);
      end

      unique case (st_q)
         io_expander_host_pkg::S_IDLE: begin    // Lines stay released while idle
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
            if (cmd_valid_in && bus_free) begin
               cmd_d   = cmd_in;
               shreg_d = {ADDR_HI, cmd_in.strap, cmd_in.rd};
               left_d  = (cmd_in.count == 8'h00) ? 8'h01 : cmd_in.count;
               rx_d    = 1'b0;
               addr_d  = 1'b1;
               bit_d   = 4'h0;
               phase_d = 2'h0;
               nack_d  = 1'b0;                  // Error flag belongs to this transfer
               st_d    = io_expander_host_pkg::S_START;
            end
         end
         io_expander_host_pkg::S_START: begin   // Data falls under high clock, then clock low
            if (tick && phase_q == 2'h0) begin
               sda_oe_d = 1'b1;
            end else if (tick && phase_q == 2'h1) begin
               scl_oe_d = 1'b1;
               phase_d  = 2'h0;
               st_d     = io_expander_host_pkg::S_BIT;
            end
         end
         io_expander_host_pkg::S_BIT: begin
            if (tick) begin
               unique case (phase_q)
                  2'h0: begin                                // Data moves under low clock
                     if (bit_q != io_expander_host_pkg::ACK_BIT) begin
                        sda_oe_d = !rx_q && !shreg_q[7];
                     end else if (rx_q) begin
                        sda_oe_d = (left_q != 8'h01);
                     end else begin
                        sda_oe_d = 1'b0;
                     end
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: begin                                // Sample mid high period
                     if (bit_q != io_expander_host_pkg::ACK_BIT) begin
                        shreg_d = {shreg_q[6:0], sda_s};
                     end else begin
                        ack_d = sda_s;
                     end
                  end
                  2'h3: begin
                     scl_oe_d = 1'b1;
                     if (bit_q != io_expander_host_pkg::ACK_BIT) begin
                        bit_d = bit_q + 4'h1;
                     end else begin
                        bit_d = 4'h0;
                        if (rx_q) begin                      // Each read byte goes out whole
                           rsp_valid_d = 1'b1;
                           rsp_d       = {shreg_q, (left_q == 8'h01)};
                           left_d      = left_q - 8'h01;
                           if (left_q == 8'h01) begin
                              st_d = io_expander_host_pkg::S_STOP;
                           end
                        end else if (ack_q) begin            // Missing ack ends it at once
                           nack_d = 1'b1;
                           st_d   = io_expander_host_pkg::S_STOP;
                        end else if (addr_q) begin
                           addr_d  = 1'b0;
                           rx_d    = cmd_q.rd;
                           shreg_d = cmd_q.rd ? io_expander_host_pkg::RST_BYTE
                                              : cmd_q.wdata;
                        end else begin
                           st_d = io_expander_host_pkg::S_STOP;
                        end
                     end
                  end
               endcase
            end
         end
         io_expander_host_pkg::S_STOP: begin    // Data low, clock high, data rises
            if (tick) begin
               unique case (phase_q)
                  2'h0: sda_oe_d = 1'b1;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  2'h3: begin
                     done_d = 1'b1;
                     st_d   = io_expander_host_pkg::S_IDLE;
                  end
               endcase
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         st_q        <= io_expander_host_pkg::S_IDLE;
         phase_q     <= 2'h0;
         qcnt_q      <= '0;
         free_q      <= '0;
         bit_q       <= 4'h0;
         shreg_q     <= io_expander_host_pkg::RST_BYTE;
         rx_q        <= 1'b0;
         addr_q      <= 1'b0;
         ack_q       <= 1'b0;
         cmd_q       <= '0;
         left_q      <= 8'h00;
         scl_oe_q    <= 1'b0;
         sda_oe_q    <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_q       <= '0;
         done_q      <= 1'b0;
         nack_q      <= 1'b0;
      end else begin
         st_q        <= st_d;
         phase_q     <= phase_d;
         qcnt_q      <= qcnt_d;
         free_q      <= free_d;
         bit_q       <= bit_d;
         shreg_q     <= shreg_d;
         rx_q        <= rx_d;
         addr_q      <= addr_d;
         ack_q       <= ack_d;
         cmd_q       <= cmd_d;
         left_q      <= left_d;
         scl_oe_q    <= scl_oe_d;
         sda_oe_q    <= sda_oe_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_q       <= rsp_d;
         done_q      <= done_d;
         nack_q      <= nack_d;
      end
   end

   // Outputs; open-drain pins only ever pull low
   assign cmd_ready_out = (st_q == io_expander_host_pkg::S_IDLE) && bus_free;
   assign rsp_valid_out = rsp_valid_q;
   assign rsp_out       = rsp_q;
   assign done_out      = done_q;
   assign nack_out      = nack_q;
   assign alert_out     = !alert_n_s;
   assign scl_out       = 1'b0;
   assign scl_oe_out    = scl_oe_q;
   assign sda_out       = 1'b0;
   assign sda_oe_out    = sda_oe_q;

   // Data drive never moves while the clock is released in a bit
   property p_sda_stable_high;
      (in_bit && !scl_oe_q && $past(!scl_oe_q)) |-> $stable(sda_oe_q);
   endproperty
   a_sda_stable_high: assert property (p_sda_stable_high)
      else $error("data changed while clock high");
   // Bit index moves only while the clock is pulled low
   property p_bit_per_pulse;
      (in_bit && $changed(bit_q)) |-> scl_oe_q;
   endproperty
   a_bit_per_pulse: assert property (p_bit_per_pulse)
      else $error("bit advanced without a clock pulse");
   // Idle leaves both lines released
   property p_idle_released;
      (in_idle && $past(in_idle)) |-> (!scl_oe_q && !sda_oe_q);
   endproperty
   a_idle_released: assert property (p_idle_released)
      else $error("line driven while idle");
   // A start is launched only after the bus was free
   property p_start_on_idle;
      (in_idle && cmd_valid_in && cmd_ready_out)
         |-> (scl_s && sda_s) ##1 (st_q == io_expander_host_pkg::S_START);
   endproperty
   a_start_on_idle: assert property (p_start_on_idle)
      else $error("start issued on a busy bus");
   // Sender side keeps data released during the ack slot
   property p_ack_release;
      (in_ack && !rx_q && phase_q != 2'h0) |-> !sda_oe_q;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("master drove data in slave ack slot");
   // Master acknowledges a read byte that is not the last
   property p_master_ack;
      (in_ack && rx_q && left_q != 8'h01 && phase_q >= 2'h1) |-> sda_oe_q;
   endproperty
   a_master_ack: assert property (p_master_ack)
      else $error("read byte left unacknowledged");
   // Last read byte gets no ack and a stop follows
   property p_last_nack;
      (in_ack && rx_q && left_q == 8'h01 && tick && phase_q == 2'h3)
         |-> !sda_oe_q ##1 (st_q == io_expander_host_pkg::S_STOP && rsp_valid_q);
   endproperty
   a_last_nack: assert property (p_last_nack)
      else $error("last read byte not closed by nack and stop");
   // Ninth pulse closes the byte and the index returns to zero
   property p_nine_pulses;
      (in_ack && tick && phase_q == 2'h3) |=> (bit_q == 4'h0 && scl_oe_q);
   endproperty
   a_nine_pulses: assert property (p_nine_pulses)
      else $error("byte did not end after ack pulse");

endmodule : io_expander_host

// [core/io_expander_host_pkg.sv]
// Purpose: Shared constants and carriers for the expander bus host.
// Assumes: 100 MHz reference clock, standard-mode serial clock.
// Notes:   Timing counts derive from times in ns and the clock period.
package io_expander_host_pkg;

   // Reference clock period in ns
   localparam int CLK_PERIOD_NS   = 10;
   // Serial clock period in ns (100 kHz)
   localparam int SCL_PERIOD_NS   = 10000;
   // Least bus free time before a start, ns
   localparam int BUS_FREE_NS     = 4700;
   // Quarter bit cycles; a longest step, so it rounds down
   localparam int QUARTER_CYC     = (SCL_PERIOD_NS / 4) / CLK_PERIOD_NS;
   // Idle cycles needed; a least time, so it rounds up
   localparam int FREE_CYC        = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Counter widths
   localparam int QCNT_W          = $clog2(QUARTER_CYC);
   localparam int FREE_W          = $clog2(FREE_CYC + 1);
   // Bit index of the acknowledge slot
   localparam logic [3:0] ACK_BIT = 4'h8;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;

   // One bus transaction asked for by the user
   typedef struct packed {
      logic       rd;        // 1: read port, 0: write port
      logic [2:0] strap;     // Strap setting of the target
      logic [7:0] wdata;     // Byte to latch on the port
      logic [7:0] count;     // Bytes to read, 0 counts as 1
   } cmd_type;

   // One byte read back from the port
   typedef struct packed {
      logic [7:0] rdata;     // Sampled port inputs
      logic       last;      // Final byte of the read
   } rsp_type;

   // Bus machine states
   typedef enum logic [1:0] {
      S_IDLE,
      S_START,
      S_BIT,
      S_STOP
   } state_type;

endpackage : io_expander_host_pkg

// [core/pin_sync.sv]
// Purpose: Two-flop synchroniser for pins entering the clock domain.
// Assumes: Inputs are levels from outside the ref_clk_in domain.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync #(
   parameter int          WIDTH   = 1,
   parameter logic [31:0] RST_VAL = 32'hffffffff
) (
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             srst_in,
   // Pin side and synchronised side
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;   // First stage, read only by the second
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;   // Second stage, safe to use
   logic [WIDTH-1:0] sync_d;

   // Next values of both stages
   always_comb begin
      meta_d = pin_in;
      sync_d = meta_q;
   end

   // Idle-high reset keeps the bus from looking busy after reset
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         meta_q <= RST_VAL[WIDTH-1:0];
         sync_q <= RST_VAL[WIDTH-1:0];
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;

endmodule : pin_sync

// [sim/io_expander_host_tb.sv]
// Purpose: Self-checking bench for the expander bus host.
// Assumes: Model device at strap 5; lines resolved with pull-ups.
// Notes:   Full-length bit timing, so each transfer takes roughly 100 to 300 microseconds.
`timescale 1ns/1ps
module io_expander_host_tb;
   localparam logic [3:0] ADDR_HI = 4'h4;  // Upper address bits, arbitrary
   localparam logic [2:0] STRAP   = 3'h5;  // Strap of the modelled device
   logic ref_clk_in, srst_in, cmd_valid_in, cmd_ready_out, rsp_valid_out;
   logic done_out, nack_out, alert_out, scl_out, scl_oe_out, sda_out, sda_oe_out;
   logic sda_pull, alert_n;                // Driven by the model
   logic [7:0] port_ext, latch, addr_seen; // Port levels and model state
   io_expander_host_pkg::cmd_type cmd_in;
   io_expander_host_pkg::rsp_type rsp_out;
   io_expander_host_pkg::rsp_type rsp_q[$]; // Read bytes in arrival order
   int n_errors, tests_run;
   wire scl_w = scl_oe_out ? scl_out : 1'b1;                 // Pull-up wins when nobody pulls
   wire sda_w = (sda_oe_out ? sda_out : 1'b1) & ~sda_pull;

   io_expander_host #(.ADDR_HI(ADDR_HI)) i_dut (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .cmd_valid_in(cmd_valid_in),
      .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
      .rsp_out(rsp_out), .done_out(done_out), .nack_out(nack_out), .alert_out(alert_out),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_out(sda_oe_out), .alert_n_in(alert_n));

   io_expander_model #(.ADDR_HI(ADDR_HI), .STRAP(STRAP)) i_dev (
      .scl_in(scl_w), .sda_in(sda_w), .sda_pull_out(sda_pull), .port_in(port_ext),
      .alert_n_out(alert_n), .latch_out(latch), .addr_out(addr_seen));

   // Clock
   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   // Collect read bytes; a pulse stands one cycle
   always @(negedge ref_clk_in) if (rsp_valid_out === 1'b1) rsp_q.push_back(rsp_out);

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One command: wait ready, hand over, wait done, bus must end idle
   task automatic run_cmd(input logic rd, input logic [2:0] strap, input logic [7:0] wd,
                          input logic [7:0] cnt);
      int n;
      n = 0;
      while (cmd_ready_out !== 1'b1 && n < 2000) begin
         @(negedge ref_clk_in);
         n++;
      end
      chk("ready", 9'h001, {8'h00, cmd_ready_out});
      cmd_in = {rd, strap, wd, cnt};
      cmd_valid_in = 1'b1;
      @(negedge ref_clk_in);
      cmd_valid_in = 1'b0;
      chk("ready while busy", 9'h000, {8'h00, cmd_ready_out});
      n = 0;
      while (done_out !== 1'b1 && n < 40000) begin
         @(negedge ref_clk_in);
         n++;
      end
      chk("done", 9'h001, {8'h00, done_out});
      chk("idle lines", 9'h003, {7'h00, scl_w, sda_w});
   endtask : run_cmd

   task automatic t_power_on();
      chk("latch at power-on", 9'h0ff, {1'b0, latch});
      chk("alert at rest", 9'h000, {8'h00, alert_out});
   endtask : t_power_on

   task automatic t_write();
      run_cmd(1'b0, STRAP, 8'h5a, 8'h01);
      chk("write latch", 9'h05a, {1'b0, latch});
      chk("write nack", 9'h000, {8'h00, nack_out});
      chk("write address", {1'b0, ADDR_HI, STRAP, 1'b0}, {1'b0, addr_seen});
   endtask : t_write

   task automatic t_read();
      port_ext = 8'hf0;
      repeat (10) @(negedge ref_clk_in);
      chk("alert on edge", 9'h001, {8'h00, alert_out});
      rsp_q.delete();
      run_cmd(1'b1, STRAP, 8'h00, 8'h02);
      chk("read count", 9'h002, {1'b0, 8'(rsp_q.size())});
      chk("read byte 0", {8'h50, 1'b0}, rsp_q[0]);
      chk("read byte 1", {8'h50, 1'b1}, rsp_q[1]);
      chk("read address", {1'b0, ADDR_HI, STRAP, 1'b1}, {1'b0, addr_seen});
      repeat (5) @(negedge ref_clk_in);
      chk("alert after read", 9'h000, {8'h00, alert_out});
   endtask : t_read

   task automatic t_wrong_strap();
      run_cmd(1'b0, 3'h2, 8'h00, 8'h01);
      chk("foreign nack", 9'h001, {8'h00, nack_out});
      chk("latch kept", 9'h05a, {1'b0, latch});
   endtask : t_wrong_strap

   task automatic test_done();
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // Watchdog: all transfers need about 60k cycles
   initial begin
      #1000000;
      n_errors++;
      test_done();
   end

   // Main sequence
   initial begin
      n_errors = 0;
      tests_run = 0;
      srst_in = 1'b1;
      cmd_valid_in = 1'b0;
      cmd_in = '0;
      port_ext = 8'hff;
      repeat (2) @(negedge ref_clk_in);
      srst_in = 1'b0;
      t_power_on();
      t_write();
      t_read();
      t_wrong_strap();
      test_done();
   end
endmodule : io_expander_host_tb

// [sim/io_expander_model.sv]
// Purpose: Behavioural expander slave on the two-wire bus for the host bench.
// Assumes: The bench resolves both wires with pull-ups; no clock stretching.
// Notes:   Read data is the port pins ANDed with the output latch.
`timescale 1ns/1ps
module io_expander_model #(
   parameter logic [3:0] ADDR_HI = 4'h4,  // Fixed upper address bits, arbitrary
   parameter logic [2:0] STRAP   = 3'h5,  // Strap pins of this device
   parameter int         HOLD_NS = 300    // Delay after clock fall before data moves
) (
   // Bus wires, clock is input only
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_pull_out,
   // Port and alert side
   input  wire logic [7:0] port_in,
   output logic            alert_n_out,
   output logic [7:0]      latch_out,
   output logic [7:0]      addr_out
);
   logic       active, first, rd, tx, nak;  // Transfer state
   logic [3:0] bitn;                         // Bit slot, 8 is the acknowledge slot
   logic [7:0] sh, ob, ref_v;                // Receive, send and alert reference
   wire  [7:0] pins = port_in & latch_out;   // Low wins on a quasi-bidirectional pin

   // Alert follows any difference from the reference
   assign alert_n_out = (pins == ref_v);

   // Power-on: port high, bus released
   initial begin
      latch_out = 8'hff;
      ref_v = 8'hff;
      active = 1'b0;
      tx = 1'b0;
      sda_pull_out = 1'b0;
      addr_out = 8'h00;
   end

   // Start restarts the byte machine, even mid-byte
   always @(negedge sda_in) if (scl_in === 1'b1) begin
      active = 1'b1;
      first = 1'b1;
      tx = 1'b0;
      bitn = 4'hf;                              // The clock fall after a start is no bit
   end

   // Stop ends the transfer; a partial byte never reaches the latch
   always @(posedge sda_in) if (scl_in === 1'b1) active = 1'b0;

   // Sample on clock rise only
   always @(posedge scl_in) if (active) begin
      if (bitn == 4'h8) nak = sda_in;
      else if (!tx) sh = {sh[6:0], sda_in};
   end

   // Advance on clock fall and set the data pull for the next slot
   always @(negedge scl_in) if (active) begin
      if (bitn == 4'h7 && !tx) begin
         if (first) begin
            addr_out = sh;
            rd = sh[0];
            active = (sh[7:1] == {ADDR_HI, STRAP});  // Silent on a foreign address
         end else begin
            latch_out = sh;
            ref_v = port_in & sh;
         end
      end
      if (bitn == 4'h8) begin
         if (first && rd) begin
            tx = 1'b1;
            ob = pins;
            ref_v = pins;
         end else if (tx && nak) active = 1'b0;      // Stop sending after no ack
         else if (tx) ob = pins;                     // Next read byte, no count limit
         first = 1'b0;
      end
      bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;    // Eight bits then one ack slot
      // Ack when receiving, release in the master's ack slot
      sda_pull_out <= #HOLD_NS active && (tx ? (bitn != 4'h8 && !ob[3'h7 - bitn[2:0]])
                                             : bitn == 4'h8);
   end
endmodule : io_expander_model
